//--- logic/pcf_config_header.sv
/*
  Function-0 configuration header register bank with command/status, class,
  latency timer, memory base, subsystem ids, interrupt and capability bytes.
  Assumes the PCI target front end decodes configuration cycles into single-cycle
  strobes on MCLK_I and delivers bus events as one-cycle pulses on the same clock.
*/
`timescale 1ns/1ns

module pcf_config_header #(
  parameter logic [7:0] REVISION_ID = 8'h01  // Arbitrary value.
) (
  input  wire logic        MCLK_I,
  input  wire logic        RESET_I,
  input  wire logic        CFG_WR_I,
  input  wire logic        CFG_RD_I,
  input  wire logic [7:0]  CFG_ADDR_I,
  input  wire logic [3:0]  CFG_BE_I,
  input  wire logic [31:0] CFG_WDATA_I,
  output logic      [31:0] CFG_RDATA_O,
  input  wire logic        ADDR_PAR_ERR_I,
  input  wire logic        DATA_PAR_ERR_I,
  input  wire logic        SERR_REQ_I,
  input  wire logic        MST_PERR_SEEN_I,
  input  wire logic        MST_ABORT_I,
  input  wire logic        TGT_ABORT_RCVD_I,
  input  wire logic        MST_BURST_START_I,
  input  wire logic        MST_ACTIVE_I,
  input  wire logic        GNT_N_I,
  output logic             MEM_DECODE_EN_O,
  output logic             BUS_MASTER_EN_O,
  output logic             PARITY_REPORT_EN_O,
  output logic             SERR_OE_O,
  output logic             SERR_O,
  output logic             TGT_ABORT_O,
  output logic             MST_END_BURST_O,
  output logic [19:0]      MEM_BASE_O,
  output logic [1:0]       DEVSEL_TIMING_O
);
  import pcf_pkg::*;

  // ==========================================================================
  // Storage.
  logic [15:0] command_r;
  logic [5:0]  status_r;
  logic [7:0]  latency_timer_r;
  logic [19:0] mem_base_r;
  logic [15:0] subsys_id_r;
  logic [15:0] subsys_vendor_r;
  logic [7:0]  int_line_r;
  logic        svid_we_r;
  logic [7:0]  lat_count_r;
  logic        lat_expired_r;
  logic [31:0] rdata_nxt;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [5:0]  status_set;
  logic [5:0]  status_clr;
  logic        serr_fire;
  logic        wr_latency;
  logic        wr_mem_base;
  logic        wr_subsys;
  logic        wr_int_line;
  logic        wr_dev_ctrl;

  // Byte enables expand into a bit mask so partial writes touch only their lanes.
  assign wmask = {{8{CFG_BE_I[3]}}, {8{CFG_BE_I[2]}}, {8{CFG_BE_I[1]}}, {8{CFG_BE_I[0]}}};
  assign wval  = CFG_WDATA_I & wmask;

  // ==========================================================================
  // Command register; only the implemented bits hold state.
  always_ff @(posedge MCLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      command_r <= CMD_RESET;
    else if (CFG_WR_I && CFG_ADDR_I == OFF_CMD_STATUS)
    begin
      if (CFG_BE_I[0])
      begin
        command_r[CMD_MEM_SPACE_BIT]   <= CFG_WDATA_I[CMD_MEM_SPACE_BIT];
        command_r[CMD_BUS_MASTER_BIT]  <= CFG_WDATA_I[CMD_BUS_MASTER_BIT];
        command_r[CMD_PARITY_RESP_BIT] <= CFG_WDATA_I[CMD_PARITY_RESP_BIT];
      end
      if (CFG_BE_I[1])
        command_r[CMD_SERR_ENABLE_BIT] <= CFG_WDATA_I[CMD_SERR_ENABLE_BIT];
    end
  end

  // Enables exported to the target decoder, master and parity logic.
  assign MEM_DECODE_EN_O    = command_r[CMD_MEM_SPACE_BIT];
  assign BUS_MASTER_EN_O    = command_r[CMD_BUS_MASTER_BIT];
  assign PARITY_REPORT_EN_O = command_r[CMD_PARITY_RESP_BIT];
  assign DEVSEL_TIMING_O    = DEVSEL_MEDIUM;

  // ==========================================================================
  // System error and target abort. SERR is only raised on address parity
  // errors while both parity response and the driver enable are on.
  assign serr_fire   = ADDR_PAR_ERR_I && command_r[CMD_PARITY_RESP_BIT]
                       && command_r[CMD_SERR_ENABLE_BIT];
  assign SERR_O      = 1'b0;
  assign SERR_OE_O   = serr_fire;
  assign TGT_ABORT_O = ADDR_PAR_ERR_I && command_r[CMD_MEM_SPACE_BIT];

  // ==========================================================================
  // Status flags, index i holds status bit 26+i, bit 24 at index 0 is remapped.
  // Index order: 0=bit24, 1=bit27, 2=bit28, 3=bit29, 4=bit30, 5=bit31.
  always_comb
  begin
    status_set    = '0;
    status_set[0] = MST_PERR_SEEN_I && command_r[CMD_PARITY_RESP_BIT];
    status_set[1] = TGT_ABORT_O;
    status_set[2] = TGT_ABORT_RCVD_I;
    status_set[3] = MST_ABORT_I;
    status_set[4] = serr_fire;
    status_set[5] = ADDR_PAR_ERR_I || DATA_PAR_ERR_I;
    status_clr    = '0;
    if (CFG_WR_I && CFG_ADDR_I == OFF_CMD_STATUS)
    begin
      status_clr[0] = CFG_BE_I[3] && CFG_WDATA_I[ST_DATA_PAR_RPT_BIT];
      status_clr[1] = CFG_BE_I[3] && CFG_WDATA_I[ST_SIG_TGT_ABORT_BIT];
      status_clr[2] = CFG_BE_I[3] && CFG_WDATA_I[ST_RCV_TGT_ABORT_BIT];
      status_clr[3] = CFG_BE_I[3] && CFG_WDATA_I[ST_RCV_MST_ABORT_BIT];
      status_clr[4] = CFG_BE_I[3] && CFG_WDATA_I[ST_SIG_SYS_ERR_BIT];
      status_clr[5] = CFG_BE_I[3] && CFG_WDATA_I[ST_DET_PAR_ERR_BIT];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_status
      always_ff @(posedge MCLK_I or posedge RESET_I)
      begin
        if (RESET_I)
          status_r[gi] <= STATUS_RESET[gi];
        else if (status_set[gi])
          status_r[gi] <= 1'b1;
        else if (status_clr[gi])
          status_r[gi] <= 1'b0;
      end
    end
  endgenerate

  // ==========================================================================
  // Write decode. One strobe per register lets every field below keep its
  // own process; apart from the command/status offset, an offset that no strobe names takes no write at all.
  assign wr_latency  = CFG_WR_I && (CFG_ADDR_I == OFF_HDR_LATENCY);
  assign wr_mem_base = CFG_WR_I && (CFG_ADDR_I == OFF_MEM_BASE);
  assign wr_subsys   = CFG_WR_I && (CFG_ADDR_I == OFF_SUBSYS_IDS);
  assign wr_int_line = CFG_WR_I && (CFG_ADDR_I == OFF_INT_BUS_TIMING);
  assign wr_dev_ctrl = CFG_WR_I && (CFG_ADDR_I == OFF_DEVICE_CONTROL);

  // ==========================================================================
  // Latency timer in clocks of MCLK_I; only lane 1 carries it.
  always_ff @(posedge MCLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      latency_timer_r <= LATENCY_RESET;
    else if (wr_latency && CFG_BE_I[1])
      latency_timer_r <= CFG_WDATA_I[15:8];
  end

  // Memory base. The low twelve bits are never stored, so no write can
  // disturb the window size and type that the host reads back.
  always_ff @(posedge MCLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      mem_base_r <= MEM_BASE_RESET;
    else if (wr_mem_base)
      mem_base_r <= (mem_base_r & ~wmask[31:12]) | wval[31:12];
  end

  // Subsystem id on lanes 3 and 2.
  always_ff @(posedge MCLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      subsys_id_r <= SUBSYS_RESET;
    else if (wr_subsys)
      subsys_id_r <= (subsys_id_r & ~wmask[31:16]) | wval[31:16];
  end

  // Subsystem vendor id on lanes 1 and 0. A write while the enable is off is
  // dropped, so a driver cannot change the subsystem vendor id by accident; the subsystem id above takes writes at any time.
  always_ff @(posedge MCLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      subsys_vendor_r <= SUBSYS_RESET;
    else if (wr_subsys && svid_we_r)
      subsys_vendor_r <= (subsys_vendor_r & ~wmask[15:0]) | wval[15:0];
  end

  // Interrupt line on lane 0; it is only storage for software.
  always_ff @(posedge MCLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      int_line_r <= INT_LINE_RESET;
    else if (wr_int_line && CFG_BE_I[0])
      int_line_r <= CFG_WDATA_I[7:0];
  end

  // Subsystem vendor id write enable in the device control byte.
  always_ff @(posedge MCLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      svid_we_r <= 1'b0;
    else if (wr_dev_ctrl && CFG_BE_I[0])
      svid_we_r <= CFG_WDATA_I[SVID_WE_BIT];
  end

  assign MEM_BASE_O = mem_base_r;

  // Counts from the start of each burst; expiry latches until the next start.
  always_ff @(posedge MCLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      lat_count_r   <= 8'h00;
      lat_expired_r <= 1'b0;
    end
    else if (MST_BURST_START_I)
    begin
      lat_count_r   <= latency_timer_r;
      lat_expired_r <= (latency_timer_r == 8'h00);
    end
    else if (MST_ACTIVE_I)
    begin
      if (lat_count_r != 8'h00)
        lat_count_r <= lat_count_r - 8'h01;
      if (lat_count_r == 8'h01)
        lat_expired_r <= 1'b1;
    end
  end

  assign MST_END_BURST_O = MST_ACTIVE_I && lat_expired_r && GNT_N_I;

  // ==========================================================================
  // Read mux. Bits that no field claims keep the zero set on entry, so
  // reserved positions read as zero; the default case zeroes unlisted offsets.
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    unique case (CFG_ADDR_I)
      OFF_CMD_STATUS:
      begin
        rdata_nxt[15:0]  = command_r;
        rdata_nxt[31]    = status_r[5];
        rdata_nxt[30]    = status_r[4];
        rdata_nxt[29]    = status_r[3];
        rdata_nxt[28]    = status_r[2];
        rdata_nxt[27]    = status_r[1];
        rdata_nxt[26:25] = DEVSEL_MEDIUM;
        rdata_nxt[24]    = status_r[0];
        rdata_nxt[23]    = FB2B_CAPABLE;
        rdata_nxt[20]    = NEW_CAPABILITIES;
      end
      OFF_CLASS_REV:
      begin
        rdata_nxt[31:8] = CLASS_CODE;
        rdata_nxt[7:0]  = REVISION_ID;
      end
      OFF_HDR_LATENCY:
      begin
        rdata_nxt[23:16] = HEADER_TYPE;
        rdata_nxt[15:8]  = latency_timer_r;
      end
      OFF_MEM_BASE:
      begin
        rdata_nxt[31:12] = mem_base_r;
        rdata_nxt[11:0]  = MEM_BASE_LOW;
      end
      OFF_SUBSYS_IDS:
      begin
        rdata_nxt[31:16] = subsys_id_r;
        rdata_nxt[15:0]  = subsys_vendor_r;
      end
      OFF_CAP_POINTER:
        rdata_nxt[7:0] = CAP_POINTER;
      OFF_INT_BUS_TIMING:
      begin
        rdata_nxt[31:24] = MAX_LATENCY;
        rdata_nxt[23:16] = MIN_GRANT;
        rdata_nxt[15:8]  = INTERRUPT_PIN;
        rdata_nxt[7:0]   = int_line_r;
      end
      OFF_DEVICE_CONTROL:
        rdata_nxt[SVID_WE_BIT] = svid_we_r;
      default:
        rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge MCLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      CFG_RDATA_O <= 32'h0000_0000;
    else if (CFG_RD_I)
      CFG_RDATA_O <= rdata_nxt;
  end

endmodule // pcf_config_header

//--- common/pcf_pkg.sv
/*
  Constants for the function-0 configuration header register bank: offsets, field
  positions, fixed values and reset values.
  Assumes a 32-bit configuration data path addressed by doubleword byte offsets.
*/
package pcf_pkg;

  // ==========================================================================
  // Register offsets (byte addresses).
  localparam logic [7:0] OFF_VENDOR_DEVICE  = 8'h00;
  localparam logic [7:0] OFF_CMD_STATUS     = 8'h04;
  localparam logic [7:0] OFF_CLASS_REV      = 8'h08;
  localparam logic [7:0] OFF_HDR_LATENCY    = 8'h0c;
  localparam logic [7:0] OFF_MEM_BASE       = 8'h10;
  localparam logic [7:0] OFF_SUBSYS_IDS     = 8'h2c;
  localparam logic [7:0] OFF_CAP_POINTER    = 8'h34;
  localparam logic [7:0] OFF_INT_BUS_TIMING = 8'h3c;
  localparam logic [7:0] OFF_DEVICE_CONTROL = 8'h40;

  // ==========================================================================
  // Command field positions.
  localparam int CMD_MEM_SPACE_BIT    = 1;
  localparam int CMD_BUS_MASTER_BIT   = 2;
  localparam int CMD_PARITY_RESP_BIT  = 6;
  localparam int CMD_SERR_ENABLE_BIT  = 8;

  // Status field positions within the 32-bit word.
  localparam int ST_DATA_PAR_RPT_BIT  = 24;
  localparam int ST_SIG_TGT_ABORT_BIT = 27;
  localparam int ST_RCV_TGT_ABORT_BIT = 28;
  localparam int ST_RCV_MST_ABORT_BIT = 29;
  localparam int ST_SIG_SYS_ERR_BIT   = 30;
  localparam int ST_DET_PAR_ERR_BIT   = 31;

  // ==========================================================================
  // Fixed values.
  localparam logic [1:0]  DEVSEL_MEDIUM      = 2'h1;
  localparam logic        FB2B_CAPABLE       = 1'h1;
  localparam logic        NEW_CAPABILITIES   = 1'h1;
  localparam logic [23:0] CLASS_CODE         = 24'h040000;
  localparam logic [7:0]  HEADER_TYPE        = 8'h80;
  localparam logic [11:0] MEM_BASE_LOW       = 12'h008;
  localparam logic [7:0]  MAX_LATENCY        = 8'h28;
  localparam logic [7:0]  MIN_GRANT          = 8'h10;
  localparam logic [7:0]  INTERRUPT_PIN      = 8'h01;
  localparam logic [7:0]  CAP_POINTER        = 8'h44;
  localparam int          SVID_WE_BIT        = 0;

  // ==========================================================================
  // Reset values.
  localparam logic [15:0] CMD_RESET          = 16'h0000;
  localparam logic [7:0]  LATENCY_RESET      = 8'h00;
  localparam logic [19:0] MEM_BASE_RESET     = 20'h00000;
  localparam logic [15:0] SUBSYS_RESET       = 16'h0000;
  localparam logic [7:0]  INT_LINE_RESET     = 8'h00;
  localparam logic [5:0]  STATUS_RESET       = 6'h00;

endpackage

//--- sim/pcf_bus_agent.sv
/*
  Bus-side partner of the configuration header: event pulses and one master burst.
  Assumes the bench requests events and bursts on MCLK_I.
*/
`timescale 1ns/1ns
module pcf_bus_agent (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [4:0] ev_i,
  input  wire logic       burst_i,
  input  wire logic       gnt_i,
  input  wire logic       master_en_i,
  input  wire logic       end_i,
  output logic      [4:0] ev_o,
  output logic            start_o,
  output logic            active_o,
  output logic            gnt_n_o
);
  // ==========================================================================
  // Burst tracking.
  logic active_r;
  assign ev_o     = ev_i;
  assign start_o  = burst_i && master_en_i && !active_r;
  assign active_o = active_r;
  assign gnt_n_o  = !gnt_i;
  // The burst ends at the edge after the header asks for it, as a real master would.
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      active_r <= 1'b0;
    else if (end_i)
      active_r <= 1'b0;
    else if (start_o)
      active_r <= 1'b1;
endmodule // pcf_bus_agent

//--- sim/pcf_monitor.sv
/*
  Checker for the configuration header ports.
  Assumes it is bound to every pcf_config_header instance.
*/
`timescale 1ns/1ns
module pcf_monitor (
  input wire logic        MCLK_I,
  input wire logic        RESET_I,
  input wire logic        CFG_WR_I,
  input wire logic        CFG_RD_I,
  input wire logic [7:0]  CFG_ADDR_I,
  input wire logic [3:0]  CFG_BE_I,
  input wire logic [31:0] CFG_WDATA_I,
  input wire logic [31:0] CFG_RDATA_O,
  input wire logic        ADDR_PAR_ERR_I,
  input wire logic        MST_ACTIVE_I,
  input wire logic        GNT_N_I,
  input wire logic        MEM_DECODE_EN_O,
  input wire logic        BUS_MASTER_EN_O,
  input wire logic        PARITY_REPORT_EN_O,
  input wire logic        SERR_OE_O,
  input wire logic        TGT_ABORT_O,
  input wire logic        MST_END_BURST_O,
  input wire logic [19:0] MEM_BASE_O,
  input wire logic [1:0]  DEVSEL_TIMING_O
);
  // ==========================================================================
  // Properties.
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);
  wire cmd_wr = CFG_WR_I && CFG_ADDR_I == 8'h04 && CFG_BE_I[0];
  wire en_any = MEM_DECODE_EN_O || BUS_MASTER_EN_O || PARITY_REPORT_EN_O;
  chk_cmd_zero: assert property (cmd_wr && CFG_BE_I[1] && CFG_WDATA_I[15:0] == 16'h0 |=> !en_any)
    else $error("zero command left an enable on");
  chk_mem_enable: assert property (cmd_wr |=> MEM_DECODE_EN_O == $past(CFG_WDATA_I[1]))
    else $error("memory enable not taken from write");
  chk_master_enable: assert property (cmd_wr |=> BUS_MASTER_EN_O == $past(CFG_WDATA_I[2]))
    else $error("master enable not taken from write");
  chk_parity_enable: assert property (cmd_wr |=> PARITY_REPORT_EN_O == $past(CFG_WDATA_I[6]))
    else $error("parity enable not taken from write");
  chk_enable_hold: assert property (!cmd_wr |=> $stable({MEM_DECODE_EN_O, BUS_MASTER_EN_O}))
    else $error("enable changed without a command write");
  chk_serr_gate: assert property (SERR_OE_O |-> ADDR_PAR_ERR_I && PARITY_REPORT_EN_O)
    else $error("error driver enabled without cause");
  chk_tgt_abort: assert property (TGT_ABORT_O == (ADDR_PAR_ERR_I && MEM_DECODE_EN_O))
    else $error("target abort does not follow address parity error");
  chk_end_burst: assert property (MST_END_BURST_O |-> MST_ACTIVE_I && GNT_N_I)
    else $error("burst end without active burst and withdrawn grant");
  chk_base_write: assert property (CFG_WR_I && CFG_ADDR_I == 8'h10 && &CFG_BE_I
    |=> MEM_BASE_O == $past(CFG_WDATA_I[31:12]))
    else $error("base address not written");
  chk_devsel_const: assert property (DEVSEL_TIMING_O == 2'h1)
    else $error("select timing not medium");
  chk_class_read: assert property (CFG_RD_I && CFG_ADDR_I == 8'h08
    |-> ##2 CFG_RDATA_O[31:8] == 24'h040000)
    else $error("class code read wrong");
  chk_reserved_zero: assert property (CFG_RD_I && CFG_ADDR_I == 8'h14 |-> ##2 CFG_RDATA_O == 32'h0)
    else $error("reserved location read nonzero");
endmodule // pcf_monitor

bind pcf_config_header pcf_monitor i_mon (.*);

//--- sim/tb.sv
/*
  Self-checking bench for pcf_config_header with the bus agent model.
  Assumes the checker is bound from its own file.
*/
`timescale 1ns/1ns
module tb;
  // ==========================================================================
  // Signals.
  localparam logic [31:0] ST = 32'h02900000;
  localparam logic [7:0] EM [5] = '{8'hc8, 8'h80, 8'h01, 8'h20, 8'h10};
  logic        MCLK_I = 1'b0, RESET_I = 1'b1, CFG_WR_I = 1'b0, CFG_RD_I = 1'b0, SERR_REQ_I = 1'b0;
  logic [7:0]  CFG_ADDR_I = 8'h0;
  logic [3:0]  CFG_BE_I = 4'h0;
  logic [31:0] CFG_WDATA_I = 32'h0, CFG_RDATA_O, seed = 32'hfec6;
  wire logic   ADDR_PAR_ERR_I, DATA_PAR_ERR_I, MST_PERR_SEEN_I, MST_ABORT_I, TGT_ABORT_RCVD_I;
  wire logic   MST_BURST_START_I, MST_ACTIVE_I, GNT_N_I;
  logic        MEM_DECODE_EN_O, BUS_MASTER_EN_O, PARITY_REPORT_EN_O, SERR_OE_O, SERR_O;
  logic        TGT_ABORT_O, MST_END_BURST_O, burst = 1'b0, gnt = 1'b1;
  logic [19:0] MEM_BASE_O;
  logic [1:0]  DEVSEL_TIMING_O, rd_p = 2'h0;
  logic [4:0]  ev = 5'h0, ev_w;
  logic [31:0] exp_q [$];
  int          fail_count = 0, check_count = 0, n, w;

  always #25 MCLK_I = ~MCLK_I;
  pcf_config_header #(.REVISION_ID(8'h5a)) i_dut (.*);  // Revision value is arbitrary.
  pcf_bus_agent i_agent (.clk_i(MCLK_I), .rst_i(RESET_I), .ev_i(ev), .burst_i(burst),
    .gnt_i(gnt), .master_en_i(BUS_MASTER_EN_O), .end_i(MST_END_BURST_O), .ev_o(ev_w),
    .start_o(MST_BURST_START_I), .active_o(MST_ACTIVE_I), .gnt_n_o(GNT_N_I));
  assign {TGT_ABORT_RCVD_I, MST_ABORT_I, MST_PERR_SEEN_I, DATA_PAR_ERR_I, ADDR_PAR_ERR_I} = ev_w;

  // ==========================================================================
  // Tasks.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] v);
    @(posedge MCLK_I);
    #2 {CFG_WR_I, CFG_ADDR_I, CFG_BE_I, CFG_WDATA_I} = {1'b1, a, b, v};
    @(posedge MCLK_I);
    #2 CFG_WR_I = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    @(posedge MCLK_I);
    #2 {CFG_RD_I, CFG_ADDR_I} = {1'b1, a};
    exp_q.push_back(want);
    @(posedge MCLK_I);
    #2 CFG_RD_I = 1'b0;
  endtask
  // Combinational responses are looked at while the event pulse stands.
  task automatic fire(input logic [4:0] m, input logic [1:0] resp);
    @(posedge MCLK_I);
    #2 ev = m;
    #1 check({29'h0, SERR_O, TGT_ABORT_O, SERR_OE_O}, {30'h0, resp});
    @(posedge MCLK_I);
    #2 ev = 5'h0;
  endtask

  // Read data is judged at the falling edge one and a half cycles after the read edge, while it still stands.
  always @(posedge MCLK_I) rd_p <= {rd_p[0], CFG_RD_I};
  always @(negedge MCLK_I)
    if (rd_p[1])
      check(CFG_RDATA_O, exp_q.pop_front());

  // ==========================================================================
  // Scenarios.
  initial
  begin
    #2000000 fail_count++;
    conclude();
  end
  initial
  begin
    repeat (12) @(posedge MCLK_I);
    #2 RESET_I = 1'b0;
    rd(8'h04, ST);
    rd(8'h08, 32'h0400005a);
    rd(8'h0c, 32'h00800000);
    rd(8'h10, 32'h00000008);
    rd(8'h2c, 32'h0);
    rd(8'h34, 32'h44);
    rd(8'h3c, 32'h28100100);
    rd(8'h14, 32'h0);
    wr(8'h08, 4'hf, 32'hffffffff);
    rd(8'h08, 32'h0400005a);
    check({30'h0, DEVSEL_TIMING_O}, 32'h1);
    wr(8'h04, 4'hf, 32'hffffffff);
    rd(8'h04, ST | 32'h146);
    check({29'h0, MEM_DECODE_EN_O, BUS_MASTER_EN_O, PARITY_REPORT_EN_O}, 32'h7);
    for (n = 0; n < 5; n++)
    begin
      fire(5'(1 << n), n == 0 ? 2'h3 : 2'h0);
      rd(8'h04, ST | 32'h146 | {EM[n], 24'h0});
      wr(8'h04, 4'h8, 32'hff000000);
      rd(8'h04, ST | 32'h146);
    end
    @(posedge MCLK_I);
    #2 ev = 5'h2;
    {CFG_WR_I, CFG_ADDR_I, CFG_BE_I, CFG_WDATA_I} = {1'b1, 8'h04, 4'h8, 32'hff000000};
    @(posedge MCLK_I);
    #2 ev = 5'h0;
    CFG_WR_I = 1'b0;
    wr(8'h04, 4'h8, 32'h0);
    rd(8'h04, ST | 32'h80000146);
    wr(8'h04, 4'hb, 32'hff000046);
    fire(5'h1, 2'h2);
    rd(8'h04, ST | 32'h88000046);
    wr(8'h04, 4'hb, 32'hff000000);
    fire(5'h5, 2'h0);
    rd(8'h04, ST | 32'h80000000);
    check({29'h0, MEM_DECODE_EN_O, BUS_MASTER_EN_O, PARITY_REPORT_EN_O}, 32'h0);
    for (n = 0; n < 4; n++)
    begin
      seed = lfsr(seed);
      wr(8'h0c, 4'hf, seed);
      rd(8'h0c, {16'h0080, seed[15:8], 8'h00});
      wr(8'h10, 4'hf, seed);
      wr(8'h10, 4'h1, ~seed);
      rd(8'h10, {seed[31:12], 12'h008});
      wr(8'h3c, 4'hf, seed);
      rd(8'h3c, {24'h281001, seed[7:0]});
      wr(8'h2c, 4'hf, seed);
      rd(8'h2c, {seed[31:16], 16'h0});
    end
    wr(8'h40, 4'h1, 32'h1);
    rd(8'h40, 32'h1);
    wr(8'h2c, 4'hf, 32'h12345678);
    rd(8'h2c, 32'h12345678);
    wr(8'h04, 4'hb, 32'hff000146);
    for (n = 0; n < 2; n++)
    begin
      wr(8'h0c, 4'h2, n == 0 ? 32'h0 : 32'h800);
      @(posedge MCLK_I);
      #2 burst = 1'b1;
      @(posedge MCLK_I);
      #2 burst = 1'b0;
      check({31'h0, MST_END_BURST_O}, 32'h0);
      gnt = 1'b0;
      #1;
      for (w = 0; w < 12 && MST_END_BURST_O !== 1'b1; w++)
      begin
        @(posedge MCLK_I);
        #1;
      end
      check(w, n == 0 ? 32'h0 : 32'h8);
      @(posedge MCLK_I);
      #2 gnt = 1'b1;
      fail_count += (w == 12);
    end
    @(posedge MCLK_I);
    #2 RESET_I = 1'b1;
    repeat (2) @(posedge MCLK_I);
    #2 RESET_I = 1'b0;
    check({29'h0, MEM_DECODE_EN_O, BUS_MASTER_EN_O, PARITY_REPORT_EN_O}, 32'h0);
    rd(8'h04, ST);
    rd(8'h0c, 32'h00800000);
    rd(8'h2c, 32'h0);
    rd(8'h40, 32'h0);
    repeat (3) @(posedge MCLK_I);
    conclude();
  end
endmodule // tb
